/* design/hdsp_pkg.sv */
// Constants, register map and state type for the datagram serial port host controller.
package hdsp_pkg;
	// ----------------------------------------------------------------
	// Register map of the controller (AXI4-Lite, byte addresses)
	// ----------------------------------------------------------------
	localparam int         ADDR_W     = 5;
	localparam int         DATA_W     = 32;
	localparam logic [4:0] REG_CTRL   = 5'h00;
	localparam logic [4:0] REG_REQ    = 5'h04;
	localparam logic [4:0] REG_REPLY  = 5'h08;
	localparam logic [4:0] REG_STATUS = 5'h0c;
	localparam logic [4:0] REG_DIV    = 5'h10;
	localparam int         CTRL_START = 0;
	localparam int         ST_BUSY    = 0;
	localparam int         ST_DONE    = 1;
	localparam int         ST_IRQ_N   = 2;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// ----------------------------------------------------------------
	// Datagram layout
	// ----------------------------------------------------------------
	localparam int         FRAME_BITS  = 32;
	localparam logic [4:0] LAST_BIT    = 5'h1f;
	localparam int         REQ_RRS_BIT = 31;
	localparam int         REQ_RW_BIT  = 24;
	localparam int         DATA_BITS   = 24;
	// Reply status byte, most significant first.
	localparam int         RPL_INT     = 31;
	localparam int         RPL_COVER   = 30;
	localparam int         RPL_LEFT3   = 29;
	localparam int         RPL_TGT3    = 28;
	localparam int         RPL_LEFT2   = 27;
	localparam int         RPL_TGT2    = 26;
	localparam int         RPL_LEFT1   = 25;
	localparam int         RPL_TGT1    = 24;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS     = 10000;
	localparam int DEV_CLK_PERIOD_PS = 62500;
	localparam int SYNC_STAGES       = 2;
	localparam int EDGE_DEV_CLKS     = 3;
	localparam int LINK_PERIOD_DEV   = 8;
	localparam int IRQ_SETTLE_DEV_X10 = 45;
	localparam int LINK_PERIOD_NS    = 1000;
	localparam int EDGE_CYCLES = (EDGE_DEV_CLKS * DEV_CLK_PERIOD_PS + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int HALF_MIN_CYCLES = (LINK_PERIOD_DEV * DEV_CLK_PERIOD_PS
		+ 2 * CLK_PERIOD_PS - 1) / (2 * CLK_PERIOD_PS);
	localparam int HALF_DEF_CYCLES = LINK_PERIOD_NS * 1000 / (2 * CLK_PERIOD_PS);
	localparam int GAP_CYCLES = (IRQ_SETTLE_DEV_X10 * DEV_CLK_PERIOD_PS
		+ 10 * CLK_PERIOD_PS - 1) / (10 * CLK_PERIOD_PS) + SYNC_STAGES;
	localparam logic [15:0] EDGE_CNT = 16'(EDGE_CYCLES);
	localparam logic [15:0] HALF_MIN = 16'(HALF_MIN_CYCLES);
	localparam logic [15:0] HALF_DEF = 16'(HALF_DEF_CYCLES);
	localparam logic [15:0] GAP_CNT  = 16'(GAP_CYCLES);

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_SETUP = 6'h02,
		ST_LOW   = 6'h04,
		ST_HIGH  = 6'h08,
		ST_HOLD  = 6'h10,
		ST_GAP   = 6'h20
	} hdsp_state_t;
endpackage : hdsp_pkg

/* design/hdsp_sync2.sv */
// Two-stage synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/10ps
module hdsp_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	// The first stage feeds the second stage only.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : hdsp_sync2

/* design/hdsp_host_ctrl.sv */
// Host controller: AXI4-Lite registers and serial datagram master for the motion device.
`timescale 1ns/10ps
module hdsp_host_ctrl (
	input  wire logic                       clock,
	input  wire logic                       rst_n,
	// AXI4-Lite slave
	input  wire logic [hdsp_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [hdsp_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [hdsp_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [hdsp_pkg::DATA_W-1:0]     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	// Serial link to the device
	output logic                            hostSelectN,
	output logic                            hostClock,
	output logic                            hostDataOut,
	input  wire logic                       hostSerialOut
);
	import hdsp_pkg::*;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [31:0]      request;
	logic [31:0]      reply;
	logic [15:0]      halfPeriod;
	logic             done;
	logic             irqStatusN;
	hdsp_state_t      state;
	logic [15:0]      count;
	logic [4:0]       bitIndex;
	logic [31:0]      txShift;
	logic [31:0]      rxShift;
	logic             serialIn;
	logic [4:0]       awAddr;
	logic             awHeld;
	logic [31:0]      wData;
	logic [3:0]       wStrb;
	logic             wHeld;
	logic             doWrite;
	logic             startReq;
	logic             frameEnd;
	logic             idle;
	logic [15:0]      halfLoad;
	logic [31:0]      readMux;
	logic             readHit;
	logic             writeHit;
	logic [31:0]      sendWord;

	// ----------------------------------------------------------------
	// Input synchroniser
	// ----------------------------------------------------------------
	// The device output may lag its own clock, so it is resynchronised here.
	hdsp_sync2 #(
		.WIDTH (1)
	) u_sync (
		.clock (clock),
		.rst_n (rst_n),
		.d     (hostSerialOut),
		.q     (serialIn)
	);

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	assign s_axi_awready = !awHeld;
	assign s_axi_wready  = !wHeld;
	assign doWrite       = awHeld && wHeld && !s_axi_bvalid;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			awHeld <= 1'b0;
			awAddr <= '0;
		end else if (s_axi_awvalid && !awHeld) begin
			awHeld <= 1'b1;
			awAddr <= s_axi_awaddr;
		end else if (doWrite) begin
			awHeld <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wHeld <= 1'b0;
			wData <= '0;
			wStrb <= '0;
		end else if (s_axi_wvalid && !wHeld) begin
			wHeld <= 1'b1;
			wData <= s_axi_wdata;
			wStrb <= s_axi_wstrb;
		end else if (doWrite) begin
			wHeld <= 1'b0;
		end
	end

	always_comb begin
		unique case ({awAddr[4:2], 2'h0})
			REG_CTRL, REG_REQ, REG_REPLY, REG_STATUS, REG_DIV: writeHit = 1'b1;
			default: writeHit = 1'b0;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= writeHit ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	assign idle     = (state == ST_IDLE);
	assign startReq = doWrite && ({awAddr[4:2], 2'h0} == REG_CTRL) && wStrb[0]
		&& wData[CTRL_START];

	// The request word is frozen while a frame is under way.
	genvar gByte;
	generate
		for (gByte = 0; gByte < 4; gByte++) begin : g_req
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					request[8*gByte +: 8] <= '0;
				end else if (doWrite && idle && ({awAddr[4:2], 2'h0} == REG_REQ)
						&& wStrb[gByte]) begin
					request[8*gByte +: 8] <= wData[8*gByte +: 8];
				end
			end
		end
	endgenerate

	// Slower clocks than the device allows are fine; faster ones are clamped.
	assign halfLoad = (wData[15:0] < HALF_MIN) ? HALF_MIN : wData[15:0];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			halfPeriod <= HALF_DEF;
		end else if (doWrite && idle && ({awAddr[4:2], 2'h0} == REG_DIV)
				&& (wStrb[1:0] == 2'h3)) begin
			halfPeriod <= halfLoad;
		end
	end

	// A frame that ends in the same cycle as a clear keeps its flag set.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			done <= 1'b0;
		end else if (frameEnd) begin
			done <= 1'b1;
		end else if (doWrite && ({awAddr[4:2], 2'h0} == REG_STATUS) && wStrb[0]
				&& wData[ST_DONE]) begin
			done <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		readMux = '0;
		readHit = 1'b1;
		unique case ({s_axi_araddr[4:2], 2'h0})
			REG_CTRL:   readMux = '0;
			REG_REQ:    readMux = request;
			REG_REPLY:  readMux = reply;
			REG_STATUS: begin
				readMux[ST_BUSY]  = !idle;
				readMux[ST_DONE]  = done;
				readMux[ST_IRQ_N] = irqStatusN;
			end
			REG_DIV:    readMux = {16'h0000, halfPeriod};
			default:    readHit = 1'b0;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= readMux;
			s_axi_rresp  <= readHit ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Frame sequencer
	// ----------------------------------------------------------------
	// A read carries no data, so its data field goes out as zeros.
	assign sendWord = request[REQ_RW_BIT] ? {request[31:DATA_BITS], {DATA_BITS{1'b0}}}
		: request;
	assign frameEnd = (state == ST_HOLD) && (count == '0);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state    <= ST_IDLE;
			count    <= '0;
			bitIndex <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (startReq) begin
						state <= ST_SETUP;
						count <= EDGE_CNT - 16'h0001;
					end
				end
				ST_SETUP: begin
					if (count == '0) begin
						state    <= ST_LOW;
						count    <= halfPeriod - 16'h0001;
						bitIndex <= '0;
					end else begin
						count <= count - 16'h0001;
					end
				end
				ST_LOW: begin
					if (count == '0) begin
						state <= ST_HIGH;
						count <= halfPeriod - 16'h0001;
					end else begin
						count <= count - 16'h0001;
					end
				end
				ST_HIGH: begin
					if (count != '0) begin
						count <= count - 16'h0001;
					end else if (bitIndex == LAST_BIT) begin
						state <= ST_HOLD;
						count <= EDGE_CNT - 16'h0001;
					end else begin
						state    <= ST_LOW;
						count    <= halfPeriod - 16'h0001;
						bitIndex <= bitIndex + 5'h01;
					end
				end
				ST_HOLD: begin
					if (count == '0) begin
						state <= ST_GAP;
						count <= GAP_CNT - 16'h0001;
					end else begin
						count <= count - 16'h0001;
					end
				end
				ST_GAP: begin
					// Long enough for the next setup and for the interrupt level to return.
					if (count == '0) begin
						state <= ST_IDLE;
					end else begin
						count <= count - 16'h0001;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Link pins
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hostSelectN <= 1'b1;
			hostClock   <= 1'b1;
		end else begin
			hostSelectN <= (state == ST_IDLE) || (state == ST_GAP) || frameEnd;
			hostClock   <= !(state == ST_LOW);
		end
	end

	// New data bit appears one cycle ahead of the falling edge, well before the next rise.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			txShift     <= '0;
			hostDataOut <= 1'b0;
		end else if (idle && startReq) begin
			txShift <= sendWord;
		end else if ((state == ST_SETUP || state == ST_HIGH) && count == '0
				&& !(state == ST_HIGH && bitIndex == LAST_BIT)) begin
			hostDataOut <= txShift[FRAME_BITS-1];
			txShift     <= {txShift[FRAME_BITS-2:0], 1'b0};
		end
	end

	// The reply bit is taken at the end of the low phase, long after the device
	// has updated its output, so the synchroniser delay does no harm.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rxShift <= '0;
		end else if (state == ST_LOW && count == '0) begin
			rxShift <= {rxShift[FRAME_BITS-2:0], serialIn};
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reply <= '0;
		end else if (frameEnd) begin
			reply <= rxShift;
		end
	end

	// While deselected the device output is its active-low interrupt level.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irqStatusN <= 1'b1;
		end else if (idle) begin
			irqStatusN <= serialIn;
		end
	end
endmodule : hdsp_host_ctrl

/* bench/hdsp_chk.sv */
// Concurrent checks on the host controller's serial link and read channel.
`timescale 1ns/10ps
module hdsp_chk (
	input wire logic                        clock,
	input wire logic                        rst_n,
	input wire logic                        s_axi_arvalid,
	input wire logic                        s_axi_arready,
	input wire logic                        s_axi_rvalid,
	input wire logic                        s_axi_rready,
	input wire logic [hdsp_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic                        hostSelectN,
	input wire logic                        hostClock,
	input wire logic                        hostDataOut
);
	import hdsp_pkg::*;
	logic [15:0] lowCnt, highCnt, selLowCnt, selHighCnt;
	logic [5:0]  riseCnt;
	logic        prevClk;
	// Idle counts saturate so that a long idle spell cannot wrap to a small value.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lowCnt     <= '0;
			highCnt    <= '0;
			selLowCnt  <= '0;
			selHighCnt <= '0;
		end else begin
			lowCnt     <= hostClock ? '0 : lowCnt + 16'h1;
			highCnt    <= !hostClock ? '0 : highCnt + {15'h0, ~&highCnt};
			selLowCnt  <= hostSelectN ? '0 : selLowCnt + 16'h1;
			selHighCnt <= !hostSelectN ? '0 : selHighCnt + {15'h0, ~&selHighCnt};
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prevClk <= 1'b1;
			riseCnt <= '0;
		end else begin
			prevClk <= hostClock;
			if (hostSelectN) begin
				riseCnt <= '0;
			end else if (hostClock && !prevClk) begin
				riseCnt <= riseCnt + 6'h1;
			end
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence frameOpen;
		$fell(hostSelectN);
	endsequence
	sequence frameClose;
		$rose(hostSelectN);
	endsequence
	idle_clock_high_a: assert property (hostSelectN |-> hostClock)
		else $error("serial clock low outside a frame");
	select_setup_a: assert property (frameOpen |-> selHighCnt >= EDGE_CNT)
		else $error("select idle too short before a frame");
	first_fall_a: assert property ($fell(hostClock) && riseCnt == 6'h0
		|-> selLowCnt >= EDGE_CNT)
		else $error("first clock fall too soon after select");
	clock_low_min_a: assert property ($rose(hostClock) |-> lowCnt >= HALF_MIN)
		else $error("serial clock low phase too short");
	clock_high_min_a: assert property ($fell(hostClock) && riseCnt != 6'h0
		|-> highCnt >= HALF_MIN)
		else $error("serial clock high phase too short");
	frame_bits_a: assert property (frameClose |-> riseCnt == 6'd32)
		else $error("frame did not carry 32 clock rises");
	select_hold_a: assert property (frameClose |-> highCnt >= EDGE_CNT)
		else $error("select rose too soon after last rise");
	// The next request bit is launched one cycle ahead of the falling clock.
	data_at_fall_a: assert property (!hostSelectN && !$past(hostSelectN)
		&& $changed(hostDataOut) |=> $fell(hostClock))
		else $error("request data changed away from a falling clock");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered one cycle after address");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before it was taken");
endmodule : hdsp_chk
bind hdsp_host_ctrl hdsp_chk hdsp_chk_inst (
	.clock(clock),
	.rst_n(rst_n),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata),
	.hostSelectN(hostSelectN),
	.hostClock(hostClock),
	.hostDataOut(hostDataOut)
);

/* bench/hdsp_dev_model.sv */
// Behavioural model of the motion device's serial host port.
`timescale 1ns/10ps
module hdsp_dev_model (
	input  wire logic        selN,
	input  wire logic        sclk,
	input  wire logic        din,
	input  wire logic [7:0]  sts,
	output logic             dout,
	output logic [31:0]      lastReq,
	output logic [15:0]      frameCnt
);
	logic        devClk;
	logic [2:0]  sSel, sClk;
	logic [1:0]  sDin;
	logic [31:0] shift, reply;
	logic [5:0]  bitCnt;
	logic [23:0] mem [128];
	// The device runs from its own 16 MHz clock, unrelated to the host clock.
	initial begin
		devClk = 1'b0;
		{sSel, sClk, sDin} = 8'hfc;
		{shift, reply, bitCnt, lastReq, frameCnt} = '0;
		dout = 1'b1;
		forever #31.25 devClk = ~devClk;
	end
	always @(posedge devClk) begin
		sSel <= {sSel[1:0], selN};
		sClk <= {sClk[1:0], sclk};
		sDin <= {sDin[0], din};
	end
	// No timeout anywhere: a stalled clock simply leaves the frame waiting.
	always @(posedge devClk) begin
		if (sSel[1]) begin
			// This is the always-driven multiplexed output; the floating and the
			// interrupt-only pin options would only change what is seen while deselected.
			dout <= #31.25 ~sts[7];
			bitCnt <= '0;
			reply <= {sts, 24'h0};
			if (!sSel[2]) begin
				lastReq <= shift;
				frameCnt <= frameCnt + 16'h1;
				if (!shift[24]) mem[shift[31:25]] <= shift[23:0];
			end
		end else if (sClk[1] && !sClk[2]) begin
			shift <= {shift[30:0], sDin[1]};
			bitCnt <= bitCnt + 6'h1;
			// Eight status bits have already gone out, so the read data goes to the top.
			if (bitCnt == 6'd7 && sDin[1]) reply[31:8] <= mem[shift[6:0]];
		end else if (!sClk[1] && sClk[2]) begin
			dout <= #31.25 reply[31];
			reply <= {reply[30:0], 1'b0};
		end
	end
endmodule : hdsp_dev_model

/* bench/hdsp_host_ctrl_tb.sv */
// Self-checking testbench for the serial port host controller.
`timescale 1ns/10ps
module hdsp_host_ctrl_tb;
	import hdsp_pkg::*;
	typedef struct packed {
		logic [31:0] req;
		logic [7:0]  sts;
		logic [31:0] expReq;
		logic [31:0] expRep;
	} hdsp_row_t;
	logic        clock, rst_n, selN, sclk, dataOut, serIn;
	logic [4:0]  awAddr, arAddr;
	logic [31:0] wData, rData, lastReq, v;
	logic [1:0]  bResp, rResp, rs;
	logic        awValid, awReady, wValid, wReady, bValid, bReady;
	logic        arValid, arReady, rValid, rReady;
	logic [7:0]  sts;
	logic [3:0]  wStrb;
	logic [15:0] frameCnt, fc0;
	int          errors, cmpCount;
	hdsp_row_t   rows [4];
	hdsp_host_ctrl hdsp_host_ctrl_inst (.clock(clock), .rst_n(rst_n),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.hostSelectN(selN), .hostClock(sclk), .hostDataOut(dataOut), .hostSerialOut(serIn));
	hdsp_dev_model hdsp_dev_model_inst (.selN(selN), .sclk(sclk), .din(dataOut), .sts(sts),
		.dout(serIn), .lastReq(lastReq), .frameCnt(frameCnt));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmpCount, errors);
		if (errors == 0 && cmpCount > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict
	task automatic giveUp(input int n);
		if (n >= 2000) begin
			errors++;
			print_verdict();
		end
	endtask : giveUp
	task automatic axiWr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic tkA, tkW, tkB;
		n = 0;
		@(posedge clock);
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		do begin
			@(negedge clock);
			tkA = awValid && awReady;
			tkW = wValid && wReady;
			tkB = bValid;
			r = bResp;
			@(posedge clock);
			if (tkA) awValid <= 1'b0;
			if (tkW) wValid <= 1'b0;
			n++;
		end while (tkB !== 1'b1 && n < 2000);
		bReady <= 1'b0;
		giveUp(n);
	endtask : axiWr
	task automatic axiRd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic tkA, tkR;
		n = 0;
		@(posedge clock);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do begin
			@(negedge clock);
			tkA = arValid && arReady;
			tkR = rValid;
			d = rData;
			r = rResp;
			@(posedge clock);
			if (tkA) arValid <= 1'b0;
			n++;
		end while (tkR !== 1'b1 && n < 2000);
		rReady <= 1'b0;
		giveUp(n);
	endtask : axiRd
	// A second start while busy must not launch another frame.
	task automatic runFrame(input logic [31:0] req, input logic twice, output logic [31:0] rep);
		int n;
		logic [31:0] s;
		n = 0;
		s = '0;
		axiWr(REG_REQ, req, rs);
		axiWr(REG_CTRL, 32'h1, rs);
		if (twice) axiWr(REG_CTRL, 32'h1, rs);
		while ((s[ST_DONE] !== 1'b1 || s[ST_BUSY] !== 1'b0) && n < 2000) begin
			axiRd(REG_STATUS, s, rs);
			n++;
		end
		giveUp(n);
		axiRd(REG_REPLY, rep, rs);
		axiWr(REG_STATUS, 32'h2, rs);
	endtask : runFrame
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		{awAddr, arAddr, wData, awValid, wValid, bReady, arValid, rReady, sts} = '0;
		{errors, cmpCount} = '0;
		wStrb = 4'hf;
		rows[0] = '{32'h1a000123, 8'ha5, 32'h1a000123, 32'ha5000000};
		rows[1] = '{32'h1bffffff, 8'h5a, 32'h1b000000, 32'h5a000123};
		rows[2] = '{32'hfe000821, 8'h00, 32'hfe000821, 32'h00000000};
		rows[3] = '{32'hff000000, 8'hff, 32'hff000000, 32'hff000821};
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		axiRd(REG_DIV, v, rs);
		check(v, 32'h32);
		axiRd(REG_REQ, v, rs);
		check(v, 32'h0);
		axiRd(REG_STATUS, v, rs);
		check(v, 32'h4);
		axiRd(5'h14, v, rs);
		check(v, 32'h0);
		check({30'h0, rs}, {30'h0, RESP_DECERR});
		axiWr(5'h18, 32'h1, rs);
		check({30'h0, rs}, {30'h0, RESP_DECERR});
		$display("reset and map test done");
		for (int i = 0; i < 4; i++) begin
			sts <= rows[i].sts;
			runFrame(rows[i].req, 1'b0, v);
			check(v, rows[i].expRep);
			check(lastReq, rows[i].expReq);
			$display("row %0d done", i);
		end
		axiWr(REG_DIV, 32'ha, rs);
		check({30'h0, rs}, {30'h0, RESP_OKAY});
		axiRd(REG_DIV, v, rs);
		check(v, 32'h19);
		check({30'h0, rs}, {30'h0, RESP_OKAY});
		fc0 = frameCnt;
		runFrame(32'h1a00beef, 1'b1, v);
		check({16'h0, frameCnt - fc0}, 32'h1);
		check(v, 32'hff000000);
		runFrame(32'h1b000000, 1'b0, v);
		check(v, 32'hff00beef);
		axiRd(REG_STATUS, v, rs);
		check(v, 32'h0);
		// A half-period write without both low byte lanes must leave the divider alone.
		wStrb <= 4'h1;
		axiWr(REG_DIV, 32'h64, rs);
		axiWr(REG_REQ, 32'hab, rs);
		wStrb <= 4'hf;
		axiRd(REG_DIV, v, rs);
		check(v, 32'h19);
		axiRd(REG_REQ, v, rs);
		check(v, 32'h1b0000ab);
		$display("fast link and busy start test done");
		sts <= 8'h00;
		fc0 = '0;
		while (v[ST_IRQ_N] !== 1'b1 && fc0 < 16'd50) begin
			axiRd(REG_STATUS, v, rs);
			fc0++;
		end
		check(v, 32'h4);
		$display("interrupt level test done");
		print_verdict();
	end
endmodule : hdsp_host_ctrl_tb
